// File: asrx_consts.svh
`ifndef ASRX_CONSTS_SVH
`define ASRX_CONSTS_SVH

// Register byte offsets.
`define ASRX_OFF_CTRL    8'h00
`define ASRX_OFF_STATUS  8'h04
`define ASRX_OFF_DATA    8'h08
`define ASRX_OFF_BAUD    8'h0C

// Control register fields.
`define ASRX_CTL_PORT_EN 0
`define ASRX_CTL_RECV_EN 1
`define ASRX_CTL_NINE    2
`define ASRX_CTL_ADDR    3
`define ASRX_CTL_ABD     4
`define ASRX_CTL_WAKE    5

// Status register fields.
`define ASRX_ST_FRAME    0
`define ASRX_ST_OVER     1
`define ASRX_ST_NINTH    2
`define ASRX_ST_AVAIL    3
`define ASRX_ST_IDLE     4
`define ASRX_ST_MEAS_OVF 5
`define ASRX_ST_COUNT    6

// Reset values.
`define ASRX_CTRL_RST    6'h00
`define ASRX_BAUD_RST    16'h0056

// Queue depth and measurement edge count.
`define ASRX_DEPTH       2
`define ASRX_SYNC_RISES  3'h5

`endif

// File: asrx_pkg.sv
package asrx_pkg;

	typedef enum logic [1:0] {
		ASRX_IDLE  = 2'b00,
		ASRX_START = 2'b01,
		ASRX_DATA  = 2'b10,
		ASRX_STOP  = 2'b11
	} asrx_state_t;

	// One queued character: ninth bit, low byte and its framing tag.
	typedef struct packed {
		logic       framingErrorFlag;
		logic       ninth;
		logic [7:0] data;
	} asrx_char_t;

	typedef struct packed {
		logic        wake;
		logic        abd;
		logic        addr;
		logic        nineBitReceiveEnable;
		logic        continuousReceiveEnable;
		logic        serialPortEnable;
	} asrx_ctrl_t;

endpackage

// File: asrx_receiver.sv
// Function
// R1 - Each queued character keeps its framing tag
// R2 - Missing stop level tags framing error
// R3 - Framing flag read-only; reading advances queue
// R4 - Port disable clears framing flag; receive-disable not
// R5 - Framing error raises no request itself
// R6 - Two-entry queue; third character sets overrun
// R7 - Overrun blocks receive; cleared by disables only
// R8 - Nine-bit mode exposes ninth bit separately
// R9 - Address filter keeps only ninth-bit-set characters
// R10 - Software toggles address filter around messages
// R11 - Measurement counter overflow sets flag, available
// R12 - Counting continues; idle low until fifth rise
// R13 - Read after overflow: fifth rise re-raises available
// R14 - Software drains buffer before clearing overflow
// R15 - Cancelled measurement: later falls become starts
// R16 - Wake mode suspends reception, watches falling edge
// R17 - Wake raises available; buffer read clears it
// R18 - Rising edge ending break clears wake enable
// R19 - Remote sends long all-zero wake character
// R20 - Non-zero character: first low is wake
// R21 - Software checks idle before enabling wake
// R22 - Sleep stops reception except wake detection
// R23 - Available follows queue non-empty
`timescale 1ns/1ps
`default_nettype none
`include "asrx_consts.svh"

module asrx_receiver
	import asrx_pkg::*;
(
	input  wire logic        clk_sys,          // System clock, 10 MHz.
	input  wire logic        nrst,             // Asynchronous reset, active low.
	input  wire logic        psel,             // APB select.
	input  wire logic        penable,          // APB access phase.
	input  wire logic        pwrite,           // APB direction.
	input  wire logic [7:0]  paddr,            // APB byte address.
	input  wire logic [31:0] pwdata,           // APB write data.
	output logic      [31:0] prdata,           // APB read data.
	output logic             pready,           // APB ready.
	output logic             pslverr,          // APB error on unmapped address.
	input  wire logic        receiveDataLine,  // Serial receive line, idle high.
	input  wire logic        sleepMode,        // Controller asleep.
	output logic             receiveAvailable  // Receive-available level.
);

	asrx_ctrl_t  ctrl;
	asrx_state_t state;
	asrx_char_t  queue [`ASRX_DEPTH];
	logic        rdPtr;
	logic        wrPtr;
	logic [1:0]  count;
	logic        overrun;
	logic        wakePend;
	logic        abdPend;
	logic        baud_measure_overflow_flag;
	logic [2:0]  riseCnt;
	logic [16:0] measCnt;
	logic [15:0] baudDiv;
	logic [15:0] bitCnt;
	logic [3:0]  bitIdx;
	logic [8:0]  shiftReg;
	logic        rxPrev;

	// Bus decode.
	wire         busDone   = psel & penable & pready;
	wire         wrDone    = busDone & pwrite;
	wire         rdDone    = busDone & ~pwrite;
	wire         hitCtrl   = (paddr == `ASRX_OFF_CTRL);
	wire         hitStatus = (paddr == `ASRX_OFF_STATUS);
	wire         hitData   = (paddr == `ASRX_OFF_DATA);
	wire         hitBaud   = (paddr == `ASRX_OFF_BAUD);
	wire         mapped    = hitCtrl | hitStatus | hitData | hitBaud;
	wire         dataRead  = rdDone & hitData;
	wire         ctrlWrite = wrDone & hitCtrl;
	wire asrx_ctrl_t wrCtrl = asrx_ctrl_t'(pwdata[5:0]);

	// Line edges.
	wire         rxFall    = rxPrev & ~receiveDataLine;
	wire         rxRise    = ~rxPrev & receiveDataLine;

	// Modes.
	// The port enable behaves as a module reset for the whole receive path.
	// Clearing it empties the queue, drops overrun and every pending event.
	wire         portOff   = ~ctrl.serialPortEnable;

	// Baud measurement takes precedence over wake detection.
	// Both modes keep the bit engine parked in its idle state.
	wire         measuring = ctrl.serialPortEnable & ctrl.abd;
	wire         waking    = ctrl.serialPortEnable & ctrl.wake & ~measuring;

	// Normal reception needs the port and continuous receive enabled.
	// Overrun freezes reception until software drops an enable.
	// Sleep stops the bit engine; the wake watcher and the baud measurement stay alive.
	wire         rxAllowed = ctrl.serialPortEnable & ctrl.continuousReceiveEnable & ~overrun // R7
		& ~measuring & ~waking & ~sleepMode;                                               // R16 R22

	// The bit counter reloads from the divisor, so a period is div plus one clocks.
	wire         bitTick   = (bitCnt == 16'h0000);

	// The data phase ends after eight or nine bits.
	wire         lastBit   = (bitIdx == (ctrl.nineBitReceiveEnable ? 4'h8 : 4'h7));  // R8

	// The stop bit is looked at once, in the middle of its period.
	wire         stopSmp   = (state == ASRX_STOP) & bitTick;

	// A low line at the stop sample marks the character as badly framed.
	// The character is still queued; the tag travels with it.
	wire         ferrNow   = ~receiveDataLine;                                         // R2

	// In eight-bit mode the ninth bit reads as zero.
	wire         ninthNow  = ctrl.nineBitReceiveEnable & shiftReg[8];

	// The address filter only has meaning with nine-bit reception.
	// Without it every character is kept, whatever the filter bit says.
	wire         keepChar  = ~(ctrl.addr & ctrl.nineBitReceiveEnable & ~ninthNow);   // R9

	// The queue is full with two unread characters.
	wire         queueFull = (count == 2'h2);

	// A kept character either enters the queue or, when it is full, raises overrun.
	// The character that overruns is lost; the two queued ones stay readable.
	wire         push      = stopSmp & keepChar & ~queueFull & rxAllowed;              // R6
	wire         setOvr    = stopSmp & keepChar & queueFull & rxAllowed;               // R6

	// A data read of an empty queue returns stale data and does not move the pointer.
	wire         pop       = dataRead & (count != 2'h0);                               // R3

	// The head is always the oldest unread character.
	wire asrx_char_t head  = queue[rdPtr];

	// In eight-bit mode the byte sits in the upper eight bits of the shifter.
	// The framing tag is stored with the character, not in a shared flag.
	wire asrx_char_t newChar = '{framingErrorFlag: ferrNow, ninth: ninthNow,
		data: (ctrl.nineBitReceiveEnable ? shiftReg[7:0] : shiftReg[8:1])};           // R1

	// Measurement.
	// Counting runs between the first and the fifth rising edge.
	// The top bit of the counter remembers a wrap, so a second wrap is not flagged again.
	wire         measRun   = measuring & (riseCnt != 3'h0);
	wire         fifthRise = measuring & rxRise & (riseCnt == (`ASRX_SYNC_RISES - 3'h1));
	wire         measWrap  = measRun & (measCnt[15:0] == 16'hFFFF) & ~measCnt[16];

	// Wake detection.
	// Any falling edge counts as the wake event, also the start of a non-zero character.
	// The remote side is expected to send a long all-zero break to avoid fragments.
	wire         wakeEvent = waking & rxFall;                                          // R16 R20

	// The rising edge that ends the break hands the line back to the bit engine.
	wire         wakeEnd   = waking & rxRise;                                          // R18

	// Queue occupancy after this cycle.
	// Push and pop may fall in one cycle; the count then stays.
	wire [1:0]   next_count = count + {1'b0, push} - {1'b0, pop};

	// Idle is low while a character or a measurement is in progress.
	wire         idleNow   = (state == ASRX_IDLE) & ~measRun;                          // R12

	// A wake event stays pending until software reads the data register.
	wire         next_wakePend = ctrl.serialPortEnable & (wakeEvent | (wakePend & ~dataRead)); // R17

	// An overflow raises a pending event; if it was read away before the fifth edge,
	// that edge raises it once more so software learns the measurement has ended.
	wire         next_abdPend  = ctrl.serialPortEnable & (measWrap
		| (fifthRise & (baud_measure_overflow_flag | measWrap) & ~abdPend)
		| (abdPend & ~dataRead));                                                      // R11 R13

	// Available is a level: queue not empty, or a pending wake or overflow event.
	// A framing error by itself adds nothing to it.
	wire         next_avail = ctrl.serialPortEnable
		& ((next_count != 2'h0) | next_wakePend | next_abdPend);                       // R5 R23

	// Status view.
	// The framing tag and the ninth bit belong to the head and read zero when empty.
	// Software must read the status before the data, since the data read advances the queue.
	wire [31:0]  statusWord = {26'h0000000, baud_measure_overflow_flag, idleNow, receiveAvailable,
		head.ninth & (count != 2'h0), overrun,
		head.framingErrorFlag & (count != 2'h0)};                                      // R1 R8

	// Register read selection.
	// Unmapped addresses read as zero and are refused with an error.
	wire [31:0]  readMux = hitCtrl   ? {26'h0000000, ctrl}
		: hitStatus ? statusWord
		: hitData   ? {24'h000000, head.data}
		: hitBaud   ? {16'h0000, baudDiv}
		: 32'h00000000;

	function automatic logic [15:0] halfBit(input logic [15:0] d);
		halfBit = {1'b0, d[15:1]};
	endfunction

	// APB slave: one wait state, then ready with data.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			// Writes return zero so a refused write never shows stale data.
			prdata  <= (psel & penable & ~pready) ? (pwrite ? 32'h00000000 : readMux) : prdata;
			pslverr <= psel & penable & ~pready & ~mapped;
		end
	end

	// Control register; hardware drops the wake and measurement enables.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl <= asrx_ctrl_t'(`ASRX_CTRL_RST);
		end else begin
			if (ctrlWrite)
				ctrl <= wrCtrl;
			if (wakeEnd & ~(ctrlWrite & wrCtrl.wake))
				ctrl.wake <= 1'b0;                                                        // R18
			if (fifthRise & ~(ctrlWrite & wrCtrl.abd))
				ctrl.abd <= 1'b0;
		end
	end

	// Baud divisor: software writes it, a clean measurement loads it.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			baudDiv <= `ASRX_BAUD_RST;
		end else if (fifthRise & ~baud_measure_overflow_flag & ~measWrap) begin
			// Eight bit periods are measured, so the divisor is the count over eight.
			baudDiv <= {3'h0, measCnt[15:3]};
		end else if (wrDone & hitBaud) begin
			baudDiv <= pwdata[15:0];
		end
	end

	// Measurement runs from the first to the fifth rising edge of the sync character.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			riseCnt <= 3'h0;
			measCnt <= 17'h00000;
			baud_measure_overflow_flag  <= 1'b0;
		end else begin
			if (!measuring) begin
				riseCnt <= 3'h0;                                                          // R15
				measCnt <= 17'h00000;
			end else if (fifthRise) begin
				riseCnt <= 3'h0;
			end else begin
				if (rxRise)
					riseCnt <= riseCnt + 3'h1;
				if (measRun)
					measCnt <= {measCnt[16] | measWrap, measCnt[15:0] + 16'h0001};        // R12
			end
			// Overflow set wins over a software clear in the same cycle.
			if (portOff)
				baud_measure_overflow_flag <= 1'b0;
			else if (measWrap)
				baud_measure_overflow_flag <= 1'b1;                                                           // R11
			else if (wrDone & hitStatus & pwdata[`ASRX_ST_MEAS_OVF])
				baud_measure_overflow_flag <= 1'b0;
		end
	end

	// Receive bit engine.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state    <= ASRX_IDLE;
			bitCnt   <= 16'h0000;
			bitIdx   <= 4'h0;
			shiftReg <= 9'h000;
			rxPrev   <= 1'b1;
		end else begin
			rxPrev <= receiveDataLine;
			if (!rxAllowed) begin
				state <= ASRX_IDLE;                                                       // R16 R22
			end else begin
				bitCnt <= bitTick ? baudDiv : bitCnt - 16'h0001;
				case (state)
					ASRX_IDLE: begin
						if (rxFall) begin
							state  <= ASRX_START;                                         // R15
							bitCnt <= halfBit(baudDiv);
						end
					end
					ASRX_START: begin
						if (bitTick) begin
							state  <= receiveDataLine ? ASRX_IDLE : ASRX_DATA;
							bitIdx <= 4'h0;
						end
					end
					ASRX_DATA: begin
						if (bitTick) begin
							shiftReg <= {receiveDataLine, shiftReg[8:1]};
							bitIdx   <= bitIdx + 4'h1;
							if (lastBit)
								state <= ASRX_STOP;
						end
					end
					ASRX_STOP: begin
						if (bitTick)
							state <= ASRX_IDLE;                                           // R3
					end
					default: state <= ASRX_IDLE;
				endcase
			end
		end
	end

	// Receive queue and its flags.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdPtr   <= 1'b0;
			wrPtr   <= 1'b0;
			count   <= 2'h0;
			overrun <= 1'b0;
			queue[0] <= '0;
			queue[1] <= '0;
		end else if (portOff) begin
			rdPtr   <= 1'b0;                                                              // R4
			wrPtr   <= 1'b0;
			count   <= 2'h0;
			overrun <= 1'b0;
		end else begin
			if (push) begin
				queue[wrPtr] <= newChar;                                                  // R1
				wrPtr        <= ~wrPtr;
			end
			if (pop)
				rdPtr <= ~rdPtr;                                                          // R3
			count <= next_count;
			if (setOvr)
				overrun <= 1'b1;                                                          // R6
			else if (!ctrl.continuousReceiveEnable)
				overrun <= 1'b0;                                                          // R7
		end
	end

	// Pending events for the available output.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wakePend         <= 1'b0;
			abdPend          <= 1'b0;
			receiveAvailable <= 1'b0;
		end else begin
			wakePend         <= next_wakePend;                                            // R17
			abdPend          <= next_abdPend;                                             // R13
			receiveAvailable <= next_avail;                                               // R23
		end
	end

endmodule // asrx_receiver
`default_nettype wire

// File: asrx_receiver_checker.sv
`timescale 1ns/1ps
`default_nettype none
module asrx_receiver_checker (
	input wire logic        clk_sys,          // System clock.
	input wire logic        nrst,             // Reset, active low.
	input wire logic        psel,             // APB select.
	input wire logic        penable,          // APB access phase.
	input wire logic        pwrite,           // APB direction.
	input wire logic [7:0]  paddr,            // APB address.
	input wire logic [31:0] prdata,           // APB read data.
	input wire logic        pready,           // APB ready.
	input wire logic        pslverr,          // APB error.
	input wire logic        receiveAvailable  // Receive-available level.
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire statusRead = pready && !pwrite && paddr == 8'h04;
	wire mapped     = paddr[1:0] == 2'b00 && paddr <= 8'h0C;
	// Only a data read or a control write may take the level down.
	wire popOrCtrl  = pready && (pwrite ? paddr == 8'h00 : paddr == 8'h08);
	sequence s_wait_ready;
		!pready ##1 pready ##1 !pready;
	endsequence
	a_ready_timing: assert property (psel && !penable |=> s_wait_ready) else $error("Ready timing wrong");
	a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("Ready without access");
	a_error_unmapped: assert property (pready && !mapped |-> pslverr) else $error("Unmapped not refused");
	a_no_error_mapped: assert property (pready && mapped |-> !pslverr) else $error("Mapped access refused");
	a_error_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("Error data not zero");
	a_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0) else $error("Upper bits set");
	a_tag_needs_char: assert property (statusRead && (prdata[0] || prdata[2]) |-> prdata[3])
		else $error("Tag shown with empty queue");
	a_avail_drop: assert property ($fell(receiveAvailable) |-> $past(popOrCtrl) || $past(popOrCtrl, 2))
		else $error("Available dropped without read");
endmodule // asrx_receiver_checker
`default_nettype wire

// File: asrx_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module asrx_tx_model (
	input  wire logic clk_sys,  // Bit timing clock.
	output var  logic lineOut   // Serial line, idle high.
);
	initial lineOut = 1'b1;
	// Holds a level for some clocks; a break is simply a long low.
	task automatic drive(input logic level, input int clocks);
		lineOut <= level;
		repeat (clocks) @(posedge clk_sys);
	endtask
	// Sixteen clocks a bit suits a divisor of 0x0F; the LSB goes first.
	task automatic send(input logic [8:0] value, input int nbits, input logic stopLevel);
		drive(1'b0, 16);
		for (int i = 0; i < nbits; i++) begin
			drive(value[i], 16);
		end
		drive(stopLevel, 16);
		drive(1'b1, 32);
	endtask
endmodule // asrx_tx_model
`default_nettype wire

// File: asrx_receiver_test.sv
`timescale 1ns/1ps
`default_nettype none
module asrx_receiver_test;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lineIn;
	logic        sleepMode = 1'b0;
	logic        receiveAvailable;
	logic [31:0] rdata;
	logic        rerr;
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	asrx_receiver u_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.receiveDataLine(lineIn), .sleepMode(sleepMode), .receiveAvailable(receiveAvailable));
	asrx_tx_model u_tx (.clk_sys(clk_sys), .lineOut(lineIn));
	always #50 clk_sys = ~clk_sys;
	task automatic test_done();
		if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// The overflow case alone needs some 66000 cycles.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata & mask, exp);
	endtask
	// Bounded wait, since the level is registered a cycle or two late.
	task automatic waitAv(input logic level, input int limit);
		for (int n = 0; n < limit && receiveAvailable !== level; n++) @(posedge clk_sys);
		chk({31'h0, receiveAvailable}, {31'h0, level});
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		rd(8'h00, 32'hFFFFFFFF, 32'h0);
		rd(8'h0C, 32'hFFFFFFFF, 32'h56);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, 8'h0C, 32'h0F);
		apb(1'b1, 8'h00, 32'h03);
		u_tx.send(9'h041, 8, 1'b1);
		u_tx.send(9'h05A, 8, 1'b0);
		u_tx.send(9'h033, 8, 1'b1);
		rd(8'h04, 32'h0B, 32'h0A);
		rd(8'h08, 32'hFF, 32'h41);
		rd(8'h04, 32'h0B, 32'h0B);
		rd(8'h08, 32'hFF, 32'h5A);
		u_tx.send(9'h077, 8, 1'b1);
		rd(8'h04, 32'h0B, 32'h02);
		apb(1'b1, 8'h00, 32'h01);
		rd(8'h04, 32'h02, 32'h0);
		apb(1'b1, 8'h00, 32'h03);
		u_tx.send(9'h012, 8, 1'b0);
		apb(1'b1, 8'h00, 32'h01);
		rd(8'h04, 32'h09, 32'h09);
		apb(1'b1, 8'h00, 32'h00);
		rd(8'h04, 32'h09, 32'h0);
		apb(1'b1, 8'h00, 32'h0F);
		u_tx.send(9'h0C3, 9, 1'b1);
		waitAv(1'b0, 4);
		u_tx.send(9'h1A5, 9, 1'b1);
		rd(8'h04, 32'h0C, 32'h0C);
		rd(8'h08, 32'hFF, 32'hA5);
		apb(1'b1, 8'h00, 32'h07);
		rd(8'h04, 32'h10, 32'h10);
		apb(1'b1, 8'h00, 32'h23);
		u_tx.drive(1'b0, 32);
		waitAv(1'b1, 4);
		rd(8'h00, 32'h20, 32'h20);
		u_tx.drive(1'b0, 180);
		u_tx.drive(1'b1, 32);
		rd(8'h00, 32'h20, 32'h0);
		rd(8'h08, 32'h0, 32'h0);
		waitAv(1'b0, 4);
		sleepMode <= 1'b1;
		u_tx.send(9'h055, 8, 1'b1);
		sleepMode <= 1'b0;
		waitAv(1'b0, 4);
		apb(1'b1, 8'h00, 32'h13);
		for (int i = 0; i < 4; i++) begin
			u_tx.drive(1'b0, 20);
			u_tx.drive(1'b1, 20);
		end
		u_tx.drive(1'b0, 66000);
		waitAv(1'b1, 4);
		rd(8'h04, 32'h30, 32'h20);
		rd(8'h08, 32'h0, 32'h0);
		waitAv(1'b0, 4);
		u_tx.drive(1'b1, 20);
		waitAv(1'b1, 4);
		rd(8'h04, 32'h10, 32'h10);
		rd(8'h08, 32'h0, 32'h0);
		apb(1'b1, 8'h04, 32'h20);
		rd(8'h04, 32'h20, 32'h0);
		test_done();
	end
endmodule // asrx_receiver_test
bind asrx_receiver asrx_receiver_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .receiveAvailable(receiveAvailable));
`default_nettype wire
